// file: afm_monitor.sv
// Actuator feedback monitor with an Avalon-MM register slave.
//
// Operation
// R1 - Check both feedbacks unswitched before enabling
// R2 - Supervise switching within timeout after enabling
// R3 - Single combined feedback wired to both inputs
// R4 - Optional startup inhibit after activation
// R5 - Startup inhibit released by reset rising edge
// R6 - Any error forces safe output false
// R7 - Feedback error cleared only by reset edge
// R8 - Reset-misuse error cleared by reset low
// R9 - Error on static reset, bad feedback, shorted inputs
// R10 - Static reset in startup wait gives C001
// R11 - First-feedback errors escalate to C011/C041
// R12 - Second-feedback errors escalate to C021/C051
// R13 - Both-feedback errors escalate to C031/C061
// R14 - Switching errors with static reset escalate
// R15 - Reset errors: ready, error set; others cleared
// R16 - First feedback false at request: C010
// R17 - Second false gives C020; both C030
// R18 - Feedback false past timeout: C040/C050/C060
// R19 - Feedback true after timeout when on: C070..C090
// R20 - Feedback true initial, false switched
// R21 - Output only with request, no inhibit, no error
// R22 - Timeout counter restarts on request change
`timescale 1ns/1ps
module afm_monitor #(
	parameter int TMR_W = 32
) (
	// Clock, reset and clock enable
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        clkEn,
	// Avalon-MM slave
	input  wire logic [3:0]  avsAddress,
	input  wire logic        avsRead,
	input  wire logic        avsWrite,
	input  wire logic [31:0] avsWriteData,
	input  wire logic [3:0]  avsByteEnable,
	output logic      [31:0] avsReadData,
	output logic             avsWaitrequest,
	// Pin inputs
	input  wire logic        outputRequest,
	input  wire logic        resetInput,
	input  wire logic        firstActuatorFeedback,
	input  wire logic        secondActuatorFeedback,
	// Pin outputs
	output logic             safeActuatorOutput,
	output logic             ready,
	output logic             error,
	output logic             protectiveRequestFlag,
	output logic             acknowledgeNeeded,
	output logic [15:0]      diagnosticCode
);

	initial
	begin
		if (TMR_W < 8 || TMR_W > 32)
			$error("afm_monitor: TMR_W must lie between 8 and 32");
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Adds 0x10, 0x20 or 0x30 to a base code by which inputs are bad.
	function automatic logic [15:0] fbCode(input logic [15:0] base,
		input logic bad1, input logic bad2);
		logic [15:0] step;
		step = (bad1 && bad2) ? 16'h0030 : (bad2 ? 16'h0020 : 16'h0010);
		return base + step;
	endfunction : fbCode

	// ----------------------------------------------------------------
	// Input synchronisation
	// ----------------------------------------------------------------
	logic [3:0] pinSync;
	logic       reqIn;
	logic       rstIn;
	logic       fb1In;
	logic       fb2In;

	afm_sync #(.W(4)) uSync (
		.clk  (clk),
		.nrst (nrst),
		.clkEn(clkEn),
		.din  ({secondActuatorFeedback, firstActuatorFeedback, resetInput, outputRequest}),
		.dout (pinSync)
	);

	assign reqIn = pinSync[0];
	assign rstIn = pinSync[1];
	assign fb1In = pinSync[2];
	assign fb2In = pinSync[3];

	// ----------------------------------------------------------------
	// Register slave
	// ----------------------------------------------------------------
	logic [1:0]       ctrl_r;
	logic [1:0]       ctrl_nxt;
	logic [TMR_W-1:0] timeout_r;
	logic [TMR_W-1:0] timeout_nxt;
	logic [31:0]      readData_nxt;
	logic             waitReq_nxt;
	logic             request;
	logic [31:0]      statusWord;
	logic [31:0]      timeoutWord;

	assign request     = avsRead || avsWrite;
	assign timeoutWord = 32'(timeout_r);

	always_comb
	begin
		statusWord = 32'h0000_0000;
		statusWord[afm_pkg::STAT_READY_BIT] = ready;
		statusWord[afm_pkg::STAT_ERROR_BIT] = error;
		statusWord[afm_pkg::STAT_OUT_BIT]   = safeActuatorOutput;
		statusWord[afm_pkg::STAT_PROT_BIT]  = protectiveRequestFlag;
		statusWord[afm_pkg::STAT_ACK_BIT]   = acknowledgeNeeded;
		statusWord[afm_pkg::STAT_FB1_BIT]   = fb1In;
		statusWord[afm_pkg::STAT_FB2_BIT]   = fb2In;
		statusWord[afm_pkg::STAT_REQ_BIT]   = reqIn;
		statusWord[afm_pkg::STAT_RST_BIT]   = rstIn;
	end

	// Every access waits exactly one cycle; writes land on the edge at
	// which waitrequest is seen low, the only edge the master counts.
	always_comb
	begin
		ctrl_nxt     = ctrl_r;
		timeout_nxt  = timeout_r;
		readData_nxt = avsReadData;
		waitReq_nxt  = !(request && avsWaitrequest);
		if (avsRead && avsWaitrequest)
		begin
			unique case (avsAddress)
				afm_pkg::REG_CTRL:    readData_nxt = {30'h0000_0000, ctrl_r};
				afm_pkg::REG_TIMEOUT: readData_nxt = timeoutWord;
				afm_pkg::REG_STATUS:  readData_nxt = statusWord;
				afm_pkg::REG_DIAG:    readData_nxt = {16'h0000, diagnosticCode};
				default:              readData_nxt = 32'h0000_0000;
			endcase
		end
		if (avsWrite && !avsWaitrequest)
		begin
			if (avsAddress == afm_pkg::REG_CTRL && avsByteEnable[0])
				ctrl_nxt = avsWriteData[1:0];
			if (avsAddress == afm_pkg::REG_TIMEOUT)
			begin
				for (int b = 0; b < 4; b++)
					if (avsByteEnable[b])
						for (int k = 0; k < 8; k++)
							if (b * 8 + k < TMR_W)
								timeout_nxt[b * 8 + k] = avsWriteData[b * 8 + k];
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			ctrl_r         <= afm_pkg::CTRL_RESET;
			timeout_r      <= TMR_W'(afm_pkg::TIMEOUT_DEFAULT_CYC);
			avsReadData    <= 32'h0000_0000;
			avsWaitrequest <= 1'b1;
		end
		else if (clkEn)
		begin
			ctrl_r         <= ctrl_nxt;
			timeout_r      <= timeout_nxt;
			avsReadData    <= readData_nxt;
			avsWaitrequest <= waitReq_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Supervision state machine
	// ----------------------------------------------------------------
	afm_pkg::afm_state_e state_r;
	afm_pkg::afm_state_e state_nxt;
	logic [15:0]      diag_nxt;
	logic [TMR_W-1:0] timer_r;
	logic [TMR_W-1:0] timer_nxt;
	logic [3:0]       prev_r;
	logic             elapsed;
	logic             rstRise;
	logic             reqRise;
	logic             fb1Rise;
	logic             fb2Rise;
	logic             coincide;
	logic             timerClr;
	logic             activate;
	logic             inhibitEn;
	logic [3:0]       errGroup;

	assign activate  = ctrl_r[afm_pkg::CTRL_ACTIVATE_BIT];
	assign inhibitEn = ctrl_r[afm_pkg::CTRL_INHIBIT_BIT];
	assign reqRise   = reqIn && !prev_r[0];
	assign rstRise   = rstIn && !prev_r[1];
	assign fb1Rise   = fb1In && !prev_r[2];
	assign fb2Rise   = fb2In && !prev_r[3];
	assign elapsed   = timer_r >= timeout_r;
	assign errGroup  = diagnosticCode[7:4];

	// A reset edge that coincides with the feedback edge of the faulty
	// input points at a wiring slip, not an operator acknowledge.
	always_comb
	begin
		unique case (errGroup)
			4'h1, 4'h4: coincide = fb1Rise; // R11
			4'h2, 4'h5: coincide = fb2Rise; // R12
			4'h3, 4'h6: coincide = fb1Rise && fb2Rise; // R13
			default:    coincide = 1'b0;
		endcase
	end

	always_comb
	begin
		state_nxt = state_r;
		diag_nxt  = diagnosticCode;
		unique case (state_r)
			afm_pkg::ST_IDLE:
				if (activate)
				begin
					state_nxt = inhibitEn ? afm_pkg::ST_STARTUP : afm_pkg::ST_WAIT_EN; // R4
					diag_nxt  = inhibitEn ? afm_pkg::DIAG_STARTUP : afm_pkg::DIAG_WAIT_EN;
				end
			afm_pkg::ST_STARTUP:
				if (rstRise)
				begin
					state_nxt = afm_pkg::ST_WAIT_EN; // R5
					diag_nxt  = afm_pkg::DIAG_WAIT_EN;
				end
				else if (rstIn)
				begin
					state_nxt = afm_pkg::ST_RST_ERR; // R10
					diag_nxt  = afm_pkg::DIAG_RST_INHIB;
				end
			afm_pkg::ST_WAIT_EN:
				if (reqRise && rstRise)
				begin
					state_nxt = afm_pkg::ST_RST_ERR; // R9
					diag_nxt  = afm_pkg::DIAG_RST_INHIB;
				end
				else if (reqRise && !(fb1In && fb2In))
				begin
					state_nxt = afm_pkg::ST_FB_ERR; // R1 R16 R17
					diag_nxt  = fbCode(afm_pkg::DIAG_EN_BASE, !fb1In, !fb2In);
				end
				else if (reqRise)
				begin
					state_nxt = afm_pkg::ST_ON;
					diag_nxt  = afm_pkg::DIAG_ON;
				end
				else if (!(fb1In && fb2In) && elapsed)
				begin
					state_nxt = afm_pkg::ST_FB_ERR; // R18 R9
					diag_nxt  = fbCode(afm_pkg::DIAG_INIT_BASE, !fb1In, !fb2In);
				end
			afm_pkg::ST_ON:
				if (!reqIn)
				begin
					state_nxt = afm_pkg::ST_WAIT_EN;
					diag_nxt  = afm_pkg::DIAG_WAIT_EN;
				end
				else if ((fb1In || fb2In) && elapsed)
				begin
					state_nxt = afm_pkg::ST_FB_ERR; // R2 R19
					diag_nxt  = fbCode(afm_pkg::DIAG_SW_BASE, fb1In, fb2In);
				end
			afm_pkg::ST_FB_ERR:
				if ((rstRise && coincide) || (rstIn && !rstRise))
				begin
					state_nxt = afm_pkg::ST_RST_ERR; // R11 R12 R13 R14
					diag_nxt  = diagnosticCode | 16'h0001;
				end
				else if (rstRise)
				begin
					state_nxt = afm_pkg::ST_WAIT_EN; // R7
					diag_nxt  = afm_pkg::DIAG_WAIT_EN;
				end
			afm_pkg::ST_RST_ERR:
				if (!rstIn)
				begin
					// Returning to the underlying fault keeps the edge
					// acknowledge mandatory after a misuse.
					if (diagnosticCode == afm_pkg::DIAG_RST_INHIB)
					begin
						state_nxt = afm_pkg::ST_STARTUP; // R8
						diag_nxt  = afm_pkg::DIAG_STARTUP;
					end
					else
					begin
						state_nxt = afm_pkg::ST_FB_ERR; // R8
						diag_nxt  = diagnosticCode & 16'hFFFE;
					end
				end
			default:
			begin
				state_nxt = afm_pkg::ST_IDLE;
				diag_nxt  = afm_pkg::DIAG_IDLE;
			end
		endcase
		if (!activate)
		begin
			state_nxt = afm_pkg::ST_IDLE;
			diag_nxt  = afm_pkg::DIAG_IDLE;
		end
	end

	// The timer measures how long the current bad condition has lasted.
	always_comb
	begin
		timerClr = (state_nxt != state_r) || (reqIn != prev_r[0]); // R22
		if (state_r == afm_pkg::ST_WAIT_EN && fb1In && fb2In)
			timerClr = 1'b1;
		if (state_r == afm_pkg::ST_ON && !fb1In && !fb2In)
			timerClr = 1'b1;
		if (timerClr)
			timer_nxt = '0;
		else if (elapsed)
			timer_nxt = timer_r;
		else
			timer_nxt = timer_r + TMR_W'(1); // R22
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			state_r               <= afm_pkg::ST_IDLE;
			diagnosticCode        <= afm_pkg::DIAG_IDLE;
			timer_r               <= '0;
			prev_r                <= 4'h0;
			safeActuatorOutput    <= 1'b0;
			ready                 <= 1'b0;
			error                 <= 1'b0;
			protectiveRequestFlag <= 1'b0;
			acknowledgeNeeded     <= 1'b0;
		end
		else if (clkEn)
		begin
			state_r               <= state_nxt;
			diagnosticCode        <= diag_nxt;
			timer_r               <= timer_nxt;
			prev_r                <= pinSync;
			safeActuatorOutput    <= (state_nxt == afm_pkg::ST_ON) && reqIn; // R21 R6
			ready                 <= state_nxt != afm_pkg::ST_IDLE; // R15
			error                 <= (state_nxt == afm_pkg::ST_FB_ERR)
				|| (state_nxt == afm_pkg::ST_RST_ERR); // R15 R6
			protectiveRequestFlag <= (state_nxt == afm_pkg::ST_STARTUP)
				|| (state_nxt == afm_pkg::ST_WAIT_EN); // R15
			acknowledgeNeeded     <= (state_nxt == afm_pkg::ST_STARTUP)
				|| ((state_nxt == afm_pkg::ST_FB_ERR) && !rstIn); // R15
		end
	end

endmodule : afm_monitor

// file: afm_pkg.sv
// Shared constants for the actuator feedback monitor.
package afm_pkg;

	// ----------------------------------------------------------------
	// Register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_CTRL    = 4'h0;
	localparam logic [3:0] REG_TIMEOUT = 4'h4;
	localparam logic [3:0] REG_STATUS  = 4'h8;
	localparam logic [3:0] REG_DIAG    = 4'hC;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_ACTIVATE_BIT = 0;
	localparam int CTRL_INHIBIT_BIT  = 1;
	localparam int STAT_READY_BIT    = 0;
	localparam int STAT_ERROR_BIT    = 1;
	localparam int STAT_OUT_BIT      = 2;
	localparam int STAT_PROT_BIT     = 3;
	localparam int STAT_ACK_BIT      = 4;
	localparam int STAT_FB1_BIT      = 5;
	localparam int STAT_FB2_BIT      = 6;
	localparam int STAT_REQ_BIT      = 7;
	localparam int STAT_RST_BIT      = 8;

	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic [1:0]  CTRL_RESET          = 2'h0;
	localparam int          TIMEOUT_DEFAULT_MS  = 0;
	localparam int          CLK_HZ              = 20000000;
	localparam int          TIMEOUT_DEFAULT_CYC = TIMEOUT_DEFAULT_MS * (CLK_HZ / 1000);

	// ----------------------------------------------------------------
	// Diagnostic codes
	// ----------------------------------------------------------------
	localparam logic [15:0] DIAG_IDLE       = 16'h0000;
	localparam logic [15:0] DIAG_STARTUP    = 16'h8401;
	localparam logic [15:0] DIAG_WAIT_EN    = 16'h8810;
	localparam logic [15:0] DIAG_ON         = 16'h8000;
	localparam logic [15:0] DIAG_RST_INHIB  = 16'hC001;
	localparam logic [15:0] DIAG_EN_BASE    = 16'hC000;
	localparam logic [15:0] DIAG_INIT_BASE  = 16'hC030;
	localparam logic [15:0] DIAG_SW_BASE    = 16'hC060;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_STARTUP,
		ST_WAIT_EN,
		ST_ON,
		ST_FB_ERR,
		ST_RST_ERR
	} afm_state_e;

endpackage : afm_pkg

// file: afm_sync.sv
// Three-stage input synchroniser with an agreement filter.
`timescale 1ns/1ps
module afm_sync #(
	parameter int W = 4
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         clkEn,
	// Data
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	initial
	begin
		if (W < 1)
			$error("afm_sync: width must be at least one");
	end

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] dout_nxt;

	// A bit moves on only when the last two stages agree, so one late
	// sample cannot produce a single-cycle glitch downstream.
	always_comb
	begin
		for (int i = 0; i < W; i++)
			dout_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : dout[i];
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			dout <= '0;
		end
		else if (clkEn)
		begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
			dout <= dout_nxt;
		end
	end

endmodule : afm_sync

// file: afm_monitor_chk.sv
// Port checker for the actuator feedback monitor.
`timescale 1ns/1ps
module afm_monitor_chk (
	// Clock and reset
	input wire logic        clk,
	input wire logic        nrst,
	// Bus handshake
	input wire logic        avsRead,
	input wire logic        avsWrite,
	input wire logic        avsWaitrequest,
	// Pins
	input wire logic        resetInput,
	input wire logic        safeActuatorOutput,
	input wire logic        ready,
	input wire logic        error,
	input wire logic        protectiveRequestFlag,
	input wire logic        acknowledgeNeeded,
	input wire logic [15:0] diagnosticCode
);
	// --------
	// Helpers
	// --------
	logic       rstErr;
	logic       fbErr;
	logic       rstPrev_r;
	logic [3:0] rstAge_r;
	logic [3:0] rstAge_nxt;
	assign rstErr = diagnosticCode[15:8] == 8'hC0 && diagnosticCode[3:0] == 4'h1;
	assign fbErr  = diagnosticCode[15:8] == 8'hC0 && diagnosticCode[3:0] == 4'h0;
	// Age of the last reset rise, saturating so it never wraps into a false match.
	always_comb
	begin
		rstAge_nxt = (rstAge_r == 4'hF) ? rstAge_r : rstAge_r + 4'h1;
		if (!nrst)
			rstAge_nxt = 4'hF;
		else if (resetInput && !rstPrev_r)
			rstAge_nxt = 4'h0;
	end
	always_ff @(posedge clk)
	begin
		rstPrev_r <= nrst && resetInput;
		rstAge_r  <= rstAge_nxt;
	end
	sequence rstLowRun;
		(rstErr && !resetInput) [*8];
	endsequence
	// --------
	// Properties
	// --------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	err_safe_a: assert property (error |-> !safeActuatorOutput)
		else $error("output on during error");
	out_gate_a: assert property (safeActuatorOutput |-> ready && !error
		&& !protectiveRequestFlag && diagnosticCode == afm_pkg::DIAG_ON)
		else $error("output on outside enabled state");
	out_entry_a: assert property ($rose(safeActuatorOutput)
		|-> $past(diagnosticCode) == afm_pkg::DIAG_WAIT_EN)
		else $error("output enabled without initial check");
	rst_err_out_a: assert property (rstErr |-> ready && error && !safeActuatorOutput
		&& !protectiveRequestFlag && !acknowledgeNeeded)
		else $error("reset error outputs wrong");
	fb_err_out_a: assert property (fbErr |-> ready && error
		&& !safeActuatorOutput && !protectiveRequestFlag)
		else $error("feedback error outputs wrong");
	fb_clear_a: assert property ($fell(error)
		&& diagnosticCode == afm_pkg::DIAG_WAIT_EN |-> rstAge_r < 4'h8)
		else $error("feedback error left without reset rise");
	rst_clear_a: assert property (rstLowRun |=> !rstErr)
		else $error("reset error kept with reset low");
	inhibit_a: assert property (diagnosticCode == afm_pkg::DIAG_STARTUP
		|-> ready && !error && !safeActuatorOutput && protectiveRequestFlag && acknowledgeNeeded)
		else $error("startup inhibit outputs wrong");
	bus_answer_a: assert property ((avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
		else $error("bus access not answered next cycle");
endmodule : afm_monitor_chk

bind afm_monitor afm_monitor_chk chk (
	.clk(clk), .nrst(nrst), .avsRead(avsRead), .avsWrite(avsWrite),
	.avsWaitrequest(avsWaitrequest), .resetInput(resetInput),
	.safeActuatorOutput(safeActuatorOutput), .ready(ready), .error(error),
	.protectiveRequestFlag(protectiveRequestFlag), .acknowledgeNeeded(acknowledgeNeeded),
	.diagnosticCode(diagnosticCode)
);

// file: afm_actuator_model.sv
// Behavioural model of two actuators with feedback contacts.
`timescale 1ns/1ps
module afm_actuator_model (
	// Clock
	input  wire logic       clk,
	// Drive and behaviour
	input  wire logic       enable,
	input  wire logic [7:0] delay1,
	input  wire logic [7:0] delay2,
	input  wire logic [1:0] fault1,
	input  wire logic [1:0] fault2,
	input  wire logic       combined,
	// Feedback contacts
	output logic            fb1,
	output logic            fb2
);
	logic [7:0] cnt [2] = '{default: 8'h00};
	logic [1:0] sw      = 2'b00;
	// Each actuator follows the drive only after its own delay in cycles.
	always @(posedge clk)
	begin
		for (int i = 0; i < 2; i++)
		begin
			if (sw[i] == enable)
				cnt[i] <= 8'h00;
			else if (cnt[i] >= (i ? delay2 : delay1))
				sw[i] <= enable;
			else
				cnt[i] <= cnt[i] + 8'h01;
		end
	end
	// Fault 1 welds a contact in its initial state, fault 2 in its switched state.
	assign fb1 = (fault1 == 2'h0) ? !sw[0] : (fault1 == 2'h1);
	assign fb2 = combined ? fb1 : (fault2 == 2'h0) ? !sw[1] : (fault2 == 2'h1);
endmodule : afm_actuator_model

// file: tb_top.sv
// Self-checking testbench for the actuator feedback monitor.
`timescale 1ns/1ps
module tb_top;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [3:0]  avsAddress = 4'h0;
	logic        avsRead = 1'b0;
	logic        avsWrite = 1'b0;
	logic [31:0] avsWriteData = 32'h0;
	logic [31:0] avsReadData;
	logic        avsWaitrequest;
	logic        outputRequest = 1'b0;
	logic        resetInput = 1'b0;
	logic        fb1, fb2, safeOut, ready, error, prot, ackNeeded;
	logic [15:0] diag;
	logic [7:0]  delay1 = 8'h02, delay2 = 8'h03;
	logic [1:0]  fault1 = 2'h0, fault2 = 2'h0;
	logic        combined = 1'b0;
	logic [31:0] rd;
	integer      seed = 32'h84181952;
	int          fail_count = 0;
	int          compares = 0;
	int          cycles = 0;
	int          j;

	always #25 clk = ~clk;

	afm_monitor DUT (.clk(clk), .nrst(nrst), .clkEn(1'b1), .avsAddress(avsAddress),
		.avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
		.avsByteEnable(4'hF), .avsReadData(avsReadData), .avsWaitrequest(avsWaitrequest),
		.outputRequest(outputRequest), .resetInput(resetInput),
		.firstActuatorFeedback(fb1), .secondActuatorFeedback(fb2),
		.safeActuatorOutput(safeOut), .ready(ready), .error(error),
		.protectiveRequestFlag(prot), .acknowledgeNeeded(ackNeeded), .diagnosticCode(diag));

	afm_actuator_model actuators (.clk(clk), .enable(safeOut), .delay1(delay1),
		.delay2(delay2), .fault1(fault1), .fault2(fault2), .combined(combined),
		.fb1(fb1), .fb2(fb2));

	// --------
	// Tasks
	// --------
	task automatic finish_test;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] data);
		@(posedge clk);
		avsAddress   <= addr;
		avsWrite     <= wr;
		avsRead      <= !wr;
		avsWriteData <= data;
		do
			@(posedge clk);
		while (avsWaitrequest !== 1'b0);
		rd = avsReadData;
		avsRead  <= 1'b0;
		avsWrite <= 1'b0;
	endtask : bus

	// Polls rather than counting cycles, since pin filtering sets the latency.
	task automatic waitDiag(input logic [15:0] exp);
		int n;
		n = 0;
		while (diag !== exp && n < 300)
		begin
			@(posedge clk);
			n++;
		end
		chk({16'h0, diag}, {16'h0, exp});
	endtask : waitDiag

	function automatic logic [15:0] expCode(input int k, input logic rst);
		return 16'hC010 + 16'(k) * 16'h0010 + {15'h0, rst};
	endfunction : expCode

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 10000)
		begin
			fail_count++;
			finish_test();
		end
	end

	// --------
	// Sequence
	// --------
	initial
	begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		bus(1'b1, afm_pkg::REG_TIMEOUT, 32'h1E);
		bus(1'b1, afm_pkg::REG_CTRL, 32'h1);
		bus(1'b0, afm_pkg::REG_CTRL, 32'h0);
		chk(rd, 32'h1);
		bus(1'b0, 4'h2, 32'h0);
		chk(rd, 32'h0);
		waitDiag(afm_pkg::DIAG_WAIT_EN);
		for (int i = 0; i < 6; i++)
		begin
			@(posedge clk);
			delay1 <= 8'($unsigned($random(seed)) % 12);
			delay2 <= 8'($unsigned($random(seed)) % 12);
			combined <= i[0];
			outputRequest <= 1'b1;
			waitDiag(afm_pkg::DIAG_ON);
			repeat (40) @(posedge clk);
			bus(1'b0, afm_pkg::REG_STATUS, 32'h0);
			chk(rd, 32'h85);
			outputRequest <= 1'b0;
			waitDiag(afm_pkg::DIAG_WAIT_EN);
			repeat (20) @(posedge clk);
		end
		// The fault codes below tell the two inputs apart, so they need separate contacts.
		combined <= 1'b0;
		for (int k = 0; k < 9; k++)
		begin
			j = k % 3;
			@(posedge clk);
			fault1 <= (j == 1) ? 2'h0 : ((k < 6) ? 2'h2 : 2'h1);
			fault2 <= (j == 0) ? 2'h0 : ((k < 6) ? 2'h2 : 2'h1);
			outputRequest <= (k < 3 || k > 5);
			waitDiag(expCode(k, 1'b0));
			@(posedge clk);
			outputRequest <= 1'b0;
			fault1 <= 2'h0;
			fault2 <= 2'h0;
			if (k < 6)
			begin
				resetInput <= 1'b1;
				waitDiag(expCode(k, 1'b1));
				@(posedge clk);
				resetInput <= 1'b0;
				waitDiag(expCode(k, 1'b0));
			end
			repeat (30) @(posedge clk);
			chk({31'h0, error}, 32'h1);
			resetInput <= 1'b1;
			waitDiag(afm_pkg::DIAG_WAIT_EN);
			@(posedge clk);
			resetInput <= 1'b0;
			repeat (10) @(posedge clk);
		end
		bus(1'b1, afm_pkg::REG_CTRL, 32'h0);
		waitDiag(afm_pkg::DIAG_IDLE);
		bus(1'b1, afm_pkg::REG_CTRL, 32'h3);
		waitDiag(afm_pkg::DIAG_STARTUP);
		outputRequest <= 1'b1;
		repeat (20) @(posedge clk);
		chk({31'h0, safeOut}, 32'h0);
		outputRequest <= 1'b0;
		resetInput <= 1'b1;
		waitDiag(afm_pkg::DIAG_WAIT_EN);
		bus(1'b1, afm_pkg::REG_CTRL, 32'h0);
		repeat (10) @(posedge clk);
		bus(1'b1, afm_pkg::REG_CTRL, 32'h3);
		waitDiag(afm_pkg::DIAG_RST_INHIB);
		resetInput <= 1'b0;
		waitDiag(afm_pkg::DIAG_STARTUP);
		resetInput <= 1'b1;
		waitDiag(afm_pkg::DIAG_WAIT_EN);
		resetInput <= 1'b0;
		repeat (10) @(posedge clk);
		outputRequest <= 1'b1;
		resetInput <= 1'b1;
		waitDiag(afm_pkg::DIAG_RST_INHIB);
		outputRequest <= 1'b0;
		resetInput <= 1'b0;
		waitDiag(afm_pkg::DIAG_STARTUP);
		finish_test();
	end
endmodule : tb_top
